//--- rtl/eth_tx_pkg.sv
package eth_tx_pkg;
	// Register offsets, byte addresses on the 8-bit register port
	localparam logic [7:0] OFS_TX_REQUEST = 8'h00;
	localparam logic [7:0] OFS_DMA_MODE   = 8'h04;
	localparam logic [7:0] OFS_FIFO_DEPTH = 8'h08;
	localparam logic [7:0] OFS_STATUS     = 8'h0c;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h10;
	localparam logic [7:0] OFS_DESC_BASE  = 8'h14;
	localparam logic [7:0] OFS_FIFO_STATE = 8'h18;

	localparam int TX_REQ_BIT     = 0;
	localparam int SOFT_RESET_BIT = 0;
	localparam int TX_DONE_BIT    = 21;
	localparam int UNDERFLOW_BIT  = 19;
	localparam int WB_DONE_BIT    = 30;

	// FIFO state register fields
	localparam int FS_WP_LSB    = 0;
	localparam int FS_RP_LSB    = 16;
	localparam int FS_TERM_BIT  = 29;
	localparam int FS_STALL_BIT = 30;
	localparam int FS_RISK_BIT  = 31;

	// FIFO geometry in 32-bit words, frame limit in bytes
	localparam int              FIFO_AW         = 9;
	localparam logic [9:0]      FIFO_WORDS      = 10'h200;
	localparam logic [9:0]      DEPTH_RESET     = 10'h200;
	localparam logic [11:0]     MAX_FRAME_BYTES = 12'h5ee;

	// Descriptor layout: word 0 control/status, word 1 length, word 2 buffer
	localparam int              DESC_ACTIVE_BIT = 31;
	localparam int              DESC_RING_BIT   = 30;
	localparam int              DESC_ERR_BIT    = 8;
	localparam logic [31:0]     DESC_STRIDE     = 32'h0000_0010;
	localparam logic [1:0]      DESC_WORDS      = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_DESC  = 3'h1,
		ST_DATA  = 3'h2,
		ST_DRAIN = 3'h3,
		ST_WB    = 3'h4
	} state_t;
endpackage

//--- rtl/eth_tx_fifo_ram.sv
`timescale 1ns/100ps
module eth_tx_fifo_ram (
	input  wire logic        clk_in,
	input  wire logic        wr_in,
	input  wire logic [8:0]  wr_addr_in,
	input  wire logic [32:0] wr_data_in,
	input  wire logic        rd_in,
	input  wire logic [8:0]  rd_addr_in,
	output logic      [32:0] rd_data_out
);
	logic [32:0] mem [0:511];

	always_ff @(posedge clk_in) begin
		if (wr_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rd_in) begin
			rd_data_out <= mem[rd_addr_in];
		end
	end
endmodule

//--- rtl/eth_tx_events.sv
`timescale 1ns/100ps
module eth_tx_events (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic [31:0] set_in,
	input  wire logic [31:0] w1c_in,
	input  wire logic        clr_wr_in,
	input  wire logic        rd_clr_in,
	input  wire logic [31:0] mask_in,
	output logic      [31:0] status_out,
	output logic             irq_out
);
	genvar i;
	generate
		for (i = 0; i < 32; i++) begin : g_bit
			logic set_ok;
			// Done flag reproduces the lost-event hazard of a clear write
			if (i == eth_tx_pkg::TX_DONE_BIT) begin : g_lossy
				assign set_ok = set_in[i] & ~clr_wr_in;
			end else begin : g_keep
				assign set_ok = set_in[i];
			end
			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					status_out[i] <= 1'b0;
				end else if (set_ok) begin
					status_out[i] <= 1'b1;
				end else if (w1c_in[i] || rd_clr_in) begin
					status_out[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign irq_out = |(status_out & mask_in);
endmodule

//--- rtl/eth_tx_dma_fifo.sv
`timescale 1ns/100ps
module eth_tx_dma_fifo (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	output logic             irq_out,
	output logic             mem_req_out,
	output logic             mem_we_out,
	output logic      [31:0] mem_addr_out,
	output logic      [31:0] mem_wdata_out,
	input  wire logic        mem_gnt_in,
	input  wire logic        mem_rvalid_in,
	input  wire logic [31:0] mem_rdata_in,
	output logic             mac_valid_out,
	input  wire logic        mac_rd_in,
	output logic      [31:0] mac_data_out,
	output logic             mac_last_out,
	output logic             mac_abort_out,
	output logic             mac_reset_out,
	output logic             rx_reset_out
);
	eth_tx_pkg::state_t state_ff;
	logic        swr_ff, srst, tx_req_ff, pend_ff, term_ff, wait_empty_ff, started_ff;
	logic [9:0]  depth_ff, fill_ff;
	logic [8:0]  wp_ff, rp_ff, rp_max;
	logic [1:0]  idx_ff;
	logic [14:0] words_left_ff;
	logic [31:0] mask_ff, base_ff, desc_ptr_ff, buf_addr_ff, word0_ff, status;
	logic [31:0] set_vec, fifo_state;
	logic        take, wb_take, fifo_wr, fifo_rd, uf, desc_idle, st_wr, ev_done;
	logic [32:0] ram_q;
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction
	function automatic logic [8:0] ptr_inc(input logic [8:0] p, input logic [9:0] d);
		ptr_inc = (p == 9'(d - 10'h001)) ? 9'h000 : p + 9'h001;
	endfunction
	assign srst   = reset_in | swr_ff;
	assign rp_max = 9'(depth_ff - 10'h001);
	assign take   = mem_req_out & mem_gnt_in;
	assign wb_take = take & (state_ff == eth_tx_pkg::ST_WB);
	assign fifo_wr = (state_ff == eth_tx_pkg::ST_DATA) & pend_ff & mem_rvalid_in;
	assign fifo_rd = mac_rd_in & mac_valid_out;
	assign st_wr   = reg_wr_in & hit(reg_addr_in, eth_tx_pkg::OFS_STATUS);
	assign ev_done = wb_take & ~term_ff;
	// MAC asks for data mid-frame while nothing is left to read
	assign uf = mac_rd_in & (fill_ff == 10'h000) & started_ff & ~term_ff & ~fifo_wr
		& (state_ff == eth_tx_pkg::ST_DATA);
	assign desc_idle = (state_ff == eth_tx_pkg::ST_DESC) & pend_ff & mem_rvalid_in
		& (idx_ff == 2'h0) & ~mem_rdata_in[eth_tx_pkg::DESC_ACTIVE_BIT];

	// Soft reset pulse, also handed to the MAC and the receive side
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			swr_ff <= 1'b0;
		end else begin
			swr_ff <= reg_wr_in & hit(reg_addr_in, eth_tx_pkg::OFS_DMA_MODE)
				& reg_wdata_in[eth_tx_pkg::SOFT_RESET_BIT];
		end
	end
	assign mac_reset_out = swr_ff;
	assign rx_reset_out  = swr_ff;

	// Request flag: set wins over the hardware clear on an inactive descriptor
	always_ff @(posedge clk_in) begin
		if (srst) begin
			tx_req_ff <= 1'b0;
		end else if (reg_wr_in && hit(reg_addr_in, eth_tx_pkg::OFS_TX_REQUEST)
				&& reg_wdata_in[eth_tx_pkg::TX_REQ_BIT]) begin
			tx_req_ff <= 1'b1;
		end else if (desc_idle) begin
			tx_req_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst) begin
			depth_ff <= eth_tx_pkg::DEPTH_RESET;
			mask_ff  <= 32'h0000_0000;
			base_ff  <= 32'h0000_0000;
		end else if (reg_wr_in) begin
			if (hit(reg_addr_in, eth_tx_pkg::OFS_FIFO_DEPTH) && reg_wdata_in[9:0] != 10'h000
					&& reg_wdata_in[9:0] <= eth_tx_pkg::FIFO_WORDS) begin
				depth_ff <= reg_wdata_in[9:0];
			end
			if (hit(reg_addr_in, eth_tx_pkg::OFS_IRQ_MASK)) begin
				mask_ff <= reg_wdata_in;
			end
			if (hit(reg_addr_in, eth_tx_pkg::OFS_DESC_BASE)) begin
				base_ff <= {reg_wdata_in[31:4], 4'h0};
			end
		end
	end

	// Descriptor and data sequencing
	always_ff @(posedge clk_in) begin
		if (srst) begin
			state_ff      <= eth_tx_pkg::ST_IDLE;
			idx_ff        <= 2'h0;
			pend_ff       <= 1'b0;
			desc_ptr_ff   <= 32'h0000_0000;
			buf_addr_ff   <= 32'h0000_0000;
			words_left_ff <= 15'h0000;
			word0_ff      <= 32'h0000_0000;
		end else begin
			if (take && !mem_we_out) begin
				pend_ff <= 1'b1;
			end else if (mem_rvalid_in) begin
				pend_ff <= 1'b0;
			end
			case (state_ff)
				eth_tx_pkg::ST_IDLE: begin
					if (reg_wr_in && hit(reg_addr_in, eth_tx_pkg::OFS_DESC_BASE)) begin
						desc_ptr_ff <= {reg_wdata_in[31:4], 4'h0};
					end else if (tx_req_ff) begin
						state_ff <= eth_tx_pkg::ST_DESC;
						idx_ff   <= 2'h0;
					end
				end
				eth_tx_pkg::ST_DESC: begin
					if (pend_ff && mem_rvalid_in) begin
						idx_ff <= idx_ff + 2'h1;
						case (idx_ff)
							2'h0: begin
								word0_ff <= mem_rdata_in;
								if (desc_idle) begin
									state_ff <= eth_tx_pkg::ST_IDLE;
								end
							end
							2'h1: begin
								words_left_ff <= 15'((17'(mem_rdata_in[15:0]) + 17'h00003) >> 2);
							end
							default: begin
								buf_addr_ff <= mem_rdata_in;
								state_ff    <= eth_tx_pkg::ST_DATA;
							end
						endcase
					end
				end
				eth_tx_pkg::ST_DATA: begin
					if (take) begin
						buf_addr_ff <= buf_addr_ff + 32'h0000_0004;
					end
					if (fifo_wr) begin
						words_left_ff <= words_left_ff - 15'h0001;
					end
					if (words_left_ff == 15'h0000 && !pend_ff) begin
						// Underflowed frame skips draining: the MAC no longer reads
						state_ff <= term_ff ? eth_tx_pkg::ST_WB : eth_tx_pkg::ST_DRAIN;
					end
				end
				eth_tx_pkg::ST_DRAIN: begin
					if (fill_ff == 10'h000) begin
						state_ff <= eth_tx_pkg::ST_WB;
					end
				end
				eth_tx_pkg::ST_WB: begin
					if (take) begin
						state_ff <= eth_tx_pkg::ST_DESC;
						idx_ff   <= 2'h0;
						desc_ptr_ff <= word0_ff[eth_tx_pkg::DESC_RING_BIT] ? base_ff
							: desc_ptr_ff + eth_tx_pkg::DESC_STRIDE;
					end
				end
				default: begin
					state_ff <= eth_tx_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Bus requests; one read outstanding keeps FIFO space accounting exact
	always_comb begin
		mem_req_out = 1'b0;
		case (state_ff)
			eth_tx_pkg::ST_DESC: mem_req_out = ~pend_ff & (idx_ff < eth_tx_pkg::DESC_WORDS);
			eth_tx_pkg::ST_DATA: mem_req_out = ~pend_ff & (words_left_ff != 15'h0000)
				& (fill_ff < depth_ff) & ~wait_empty_ff;
			eth_tx_pkg::ST_WB:   mem_req_out = 1'b1;
			default:             mem_req_out = 1'b0;
		endcase
	end
	assign mem_we_out    = (state_ff == eth_tx_pkg::ST_WB);
	assign mem_addr_out  = (state_ff == eth_tx_pkg::ST_DATA) ? buf_addr_ff
		: desc_ptr_ff + (mem_we_out ? 32'h0000_0000 : {28'h0000000, idx_ff, 2'h0});
	assign mem_wdata_out = (word0_ff & ~(32'h1 << eth_tx_pkg::DESC_ACTIVE_BIT))
		| (32'(term_ff) << eth_tx_pkg::DESC_ERR_BIT);

	// FIFO pointers and fill level
	always_ff @(posedge clk_in) begin
		if (srst || (wb_take && term_ff)) begin
			wp_ff         <= 9'h000;
			rp_ff         <= srst ? 9'(eth_tx_pkg::DEPTH_RESET - 10'h001) : rp_max;
			fill_ff       <= 10'h000;
			term_ff       <= 1'b0;
			wait_empty_ff <= 1'b0;
		end else if (uf) begin
			term_ff <= 1'b1;
			rp_ff   <= rp_max;
			// Stale slots below the write pointer now count as occupied
			fill_ff <= {1'b0, wp_ff};
		end else begin
			if (fifo_wr) begin
				wp_ff <= ptr_inc(wp_ff, depth_ff);
			end
			if (fifo_rd) begin
				rp_ff <= ptr_inc(rp_ff, depth_ff);
			end
			fill_ff <= fill_ff + 10'(fifo_wr) - 10'(fifo_rd);
			// No reader remains after underflow, so only a soft reset ends this wait
			if (term_ff && fill_ff == depth_ff && words_left_ff != 15'h0000) begin
				wait_empty_ff <= 1'b1;
			end else if (fill_ff == 10'h000) begin
				wait_empty_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst || wb_take) begin
			started_ff <= 1'b0;
		end else if (fifo_rd) begin
			started_ff <= 1'b1;
		end
	end
	assign mac_valid_out = (fill_ff != 10'h000) & ~term_ff;
	assign mac_abort_out = term_ff;
	assign mac_data_out  = ram_q[31:0];
	assign mac_last_out  = ram_q[32];
	eth_tx_fifo_ram u_ram (
		.clk_in      (clk_in),
		.wr_in       (fifo_wr),
		.wr_addr_in  (wp_ff),
		.wr_data_in  ({words_left_ff == 15'h0001, mem_rdata_in}),
		.rd_in       (fifo_rd),
		.rd_addr_in  (ptr_inc(rp_ff, depth_ff)),
		.rd_data_out (ram_q)
	);
	assign set_vec = (32'(ev_done) << eth_tx_pkg::TX_DONE_BIT)
		| (32'(uf) << eth_tx_pkg::UNDERFLOW_BIT)
		| (32'(wb_take) << eth_tx_pkg::WB_DONE_BIT);
	eth_tx_events u_events (
		.clk_in     (clk_in),
		.reset_in   (srst),
		.set_in     (set_vec),
		.w1c_in     (st_wr ? reg_wdata_in : 32'h0000_0000),
		.clr_wr_in  (st_wr),
		.rd_clr_in  (reg_rd_in & hit(reg_addr_in, eth_tx_pkg::OFS_STATUS)),
		.mask_in    (mask_ff),
		.status_out (status),
		.irq_out    (irq_out)
	);
	always_comb begin
		fifo_state = 32'h0000_0000;
		fifo_state[eth_tx_pkg::FS_WP_LSB +: 9] = wp_ff;
		fifo_state[eth_tx_pkg::FS_RP_LSB +: 9] = rp_ff;
		fifo_state[eth_tx_pkg::FS_TERM_BIT]    = term_ff;
		fifo_state[eth_tx_pkg::FS_STALL_BIT]   = wait_empty_ff & term_ff;
		fifo_state[eth_tx_pkg::FS_RISK_BIT]    = {depth_ff, 2'h0} <= eth_tx_pkg::MAX_FRAME_BYTES;
	end
	always_ff @(posedge clk_in) begin
		if (reset_in || !reg_rd_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else begin
			case (reg_addr_in)
				eth_tx_pkg::OFS_TX_REQUEST: reg_rdata_out <= 32'(tx_req_ff);
				eth_tx_pkg::OFS_FIFO_DEPTH: reg_rdata_out <= 32'(depth_ff);
				eth_tx_pkg::OFS_STATUS:     reg_rdata_out <= status;
				eth_tx_pkg::OFS_IRQ_MASK:   reg_rdata_out <= mask_ff;
				eth_tx_pkg::OFS_DESC_BASE:  reg_rdata_out <= base_ff;
				eth_tx_pkg::OFS_FIFO_STATE: reg_rdata_out <= fifo_state;
				default:                    reg_rdata_out <= 32'h0000_0000;
			endcase
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	AST_REQ_START: assert property (
		state_ff == eth_tx_pkg::ST_IDLE && tx_req_ff && !reg_wr_in && !swr_ff
		|=> state_ff == eth_tx_pkg::ST_DESC) else $error("request did not start fetch");
	AST_DONE_SET: assert property (
		ev_done && !st_wr && !swr_ff |=> status[eth_tx_pkg::TX_DONE_BIT])
		else $error("done flag not set");
	AST_NO_GRANT: assert property (
		state_ff == eth_tx_pkg::ST_DATA && !pend_ff && !take |=> !fifo_wr)
		else $error("FIFO written without bus transfer");
	AST_UF_RESUME: assert property (
		state_ff == eth_tx_pkg::ST_DATA && term_ff && words_left_ff == 15'h0000 && !pend_ff
		&& !swr_ff |=> state_ff == eth_tx_pkg::ST_WB ##0 mem_req_out && mem_we_out)
		else $error("no write-back after underflow");
	AST_SRST_PTR: assert property (
		swr_ff |=> wp_ff == 9'h000 && rp_ff == rp_max && fill_ff == 10'h000)
		else $error("soft reset pointers wrong");
	AST_WP_STEP: assert property (
		fifo_wr && !srst && !uf |=> wp_ff == ptr_inc($past(wp_ff), depth_ff))
		else $error("write pointer did not step");
	AST_ONE_FRAME: assert property (
		state_ff == eth_tx_pkg::ST_DRAIN |-> !mem_req_out) else $error("fetch during drain");
	AST_UF_TERM: assert property (
		uf && !swr_ff |=> term_ff && !mac_valid_out && rp_ff == rp_max)
		else $error("underflow did not stop reading");
	AST_WAIT_EMPTY: assert property (
		wait_empty_ff |-> !mem_req_out || state_ff != eth_tx_pkg::ST_DATA)
		else $error("data fetched while waiting for empty");
	AST_STALL_HOLD: assert property (
		disable iff (srst) wait_empty_ff && term_ff |=> state_ff == eth_tx_pkg::ST_DATA [*3])
		else $error("stall released without soft reset");
	AST_SWR_OUT: assert property (
		reg_wr_in && hit(reg_addr_in, eth_tx_pkg::OFS_DMA_MODE) && reg_wdata_in[0]
		|=> mac_reset_out && rx_reset_out ##1 state_ff == eth_tx_pkg::ST_IDLE)
		else $error("soft reset not propagated");
	AST_ACTIVE_CLR: assert property (
		mem_we_out |-> !mem_wdata_out[eth_tx_pkg::DESC_ACTIVE_BIT])
		else $error("write-back left active set");
	AST_FILL_BOUND: assert property (
		fill_ff <= depth_ff) else $error("fill above depth");
	COV_UF: cover property (uf);
	COV_STALL: cover property (wait_empty_ff && term_ff);
	COV_WB: cover property (ev_done);
endmodule

//--- tb/eth_tx_partner.sv
`timescale 1ns/100ps
module eth_tx_partner (
	input  wire logic        clk_in,
	input  wire logic        mem_req_in,
	input  wire logic        mem_we_in,
	input  wire logic [31:0] mem_addr_in,
	input  wire logic [31:0] mem_wdata_in,
	input  wire logic [15:0] budget_in,
	input  wire logic        mac_go_in,
	input  wire logic        mac_valid_in,
	input  wire logic [31:0] mac_data_in,
	input  wire logic        mac_last_in,
	output logic             mem_gnt_out,
	output logic             mem_rvalid_out = 1'b0,
	output logic      [31:0] mem_rdata_out = 32'h0,
	output logic             mac_rd_out = 1'b0
);
	logic [31:0] mem [0:63];
	logic [15:0] grants = 16'h0;
	logic        taken;
	logic        mac_took = 1'b0;
	logic [31:0] got [$];
	logic        last_got [$];
	// Descriptors start inactive so the first ownership check passes
	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = 32'h0000_0000;
		end
	end
	// Spent budget stands for another master holding the bus
	assign mem_gnt_out = mem_req_in && (grants < budget_in);
	assign taken = mem_req_in && mem_gnt_out;
	always @(posedge clk_in) begin
		grants <= grants + {15'h0, taken};
		mem_rvalid_out <= taken && !mem_we_in;
		// Idle data bus inverts every cycle, showing the last word again on alternate idle cycles
		mem_rdata_out <= (taken && !mem_we_in) ? mem[mem_addr_in[7:2]] : ~mem_rdata_out;
		if (taken && mem_we_in) begin
			mem[mem_addr_in[7:2]] <= mem_wdata_in;
		end
		// Real MAC keeps pulling mid-frame whether data are ready or not
		mac_rd_out <= mac_go_in;
		mac_took <= mac_rd_out && mac_valid_in;
		if (mac_took) begin
			got.push_back(mac_data_in);
			last_got.push_back(mac_last_in);
		end
	end
endmodule

//--- tb/testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [7:0]  reg_addr_in = 8'h0;
	logic [31:0] reg_wdata_in = 32'h0;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in, mac_data_out;
	logic        irq_out, mem_req_out, mem_we_out, mem_gnt_in, mem_rvalid_in;
	logic        mac_valid_out, mac_rd_in, mac_last_out, mac_abort_out;
	logic        mac_reset_out, rx_reset_out;
	logic [15:0] budget = 16'hffff;
	logic        mac_go = 1'b0;
	logic [31:0] rd;
	int          n_fail = 0;
	int          checks = 0;
	int          cycles = 0;

	always #4 clk_in = ~clk_in;

	eth_tx_dma_fifo dut (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .mem_req_out(mem_req_out),
		.mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
		.mem_gnt_in(mem_gnt_in), .mem_rvalid_in(mem_rvalid_in), .mem_rdata_in(mem_rdata_in),
		.mac_valid_out(mac_valid_out), .mac_rd_in(mac_rd_in), .mac_data_out(mac_data_out),
		.mac_last_out(mac_last_out), .mac_abort_out(mac_abort_out),
		.mac_reset_out(mac_reset_out), .rx_reset_out(rx_reset_out));

	eth_tx_partner partner (.clk_in(clk_in), .mem_req_in(mem_req_out), .mem_we_in(mem_we_out),
		.mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .budget_in(budget),
		.mac_go_in(mac_go), .mac_valid_in(mac_valid_out), .mac_data_in(mac_data_out),
		.mac_last_in(mac_last_out), .mem_gnt_out(mem_gnt_in), .mem_rvalid_out(mem_rvalid_in),
		.mem_rdata_out(mem_rdata_in), .mac_rd_out(mac_rd_in));

	task automatic complete_run();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			complete_run();
		end
	end

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		#1;
	endtask

	task automatic reg_rd(input logic [7:0] a);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		rd = reg_rdata_out;
	endtask

	// Bounded polling so a dead engine ends as a mismatch, not a hang
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		for (int i = 0; i < 300; i++) begin
			reg_rd(a);
			if ((rd & m) === v) break;
		end
		`CHK("poll", v, rd & m)
	endtask

	task automatic start_tx(input logic [31:0] len, input int words);
		`CHK("desc free", 1'b0, partner.mem[0][31])
		for (int i = 0; i < words; i++) partner.mem[16 + i] = 32'ha5a5_0000 + i;
		partner.mem[0] = 32'hc000_0000;
		partner.mem[1] = len;
		partner.mem[2] = 32'h0000_0040;
		partner.got.delete();
		partner.last_got.delete();
		reg_rd(eth_tx_pkg::OFS_TX_REQUEST);
		`CHK("req idle", 1'b0, rd[0])
		reg_wr(eth_tx_pkg::OFS_TX_REQUEST, 32'h1);
	endtask

	// Grant only descriptor and two words, then let the MAC pull dry
	task automatic starve();
		budget = partner.grants + 16'h5;
		for (int i = 0; i < 200 && partner.grants != budget; i++) @(posedge clk_in);
		repeat (3) @(posedge clk_in);
		mac_go <= 1'b1;
		for (int i = 0; i < 20 && mac_abort_out !== 1'b1; i++) @(posedge clk_in);
		#1;
		`CHK("abort", 1'b1, mac_abort_out)
		mac_go <= 1'b0;
		budget <= 16'hffff;
		`CHK("words", 2, partner.got.size())
	endtask

	task automatic check_reset();
		reg_rd(eth_tx_pkg::OFS_FIFO_DEPTH);
		`CHK("depth", 32'h200, rd)
		reg_rd(eth_tx_pkg::OFS_FIFO_STATE);
		`CHK("wp", 9'h0, rd[8:0])
		`CHK("rp init", 9'h1ff, rd[24:16])
		reg_rd(8'h1c);
		`CHK("unmapped", 32'h0, rd)
		`CHK("irq", 1'b0, irq_out)
	endtask

	task automatic normal_frame();
		reg_wr(eth_tx_pkg::OFS_IRQ_MASK, 32'h1 << eth_tx_pkg::TX_DONE_BIT);
		reg_wr(eth_tx_pkg::OFS_DESC_BASE, 32'h0);
		start_tx(32'd12, 3);
		poll(eth_tx_pkg::OFS_FIFO_STATE, 32'h1ff, 32'h3);
		@(posedge clk_in);
		mac_go <= 1'b1;
		repeat (3) @(posedge clk_in);
		mac_go <= 1'b0;
		poll(eth_tx_pkg::OFS_TX_REQUEST, 32'h1, 32'h0);
		`CHK("active", 1'b0, partner.mem[0][31])
		for (int i = 0; i < 3; i++) `CHK("data", 32'ha5a5_0000 + i, partner.got[i])
		`CHK("last", 3'b001, {partner.last_got[0], partner.last_got[1], partner.last_got[2]})
		`CHK("irq done", 1'b1, irq_out)
		reg_wr(eth_tx_pkg::OFS_IRQ_MASK, 32'h0);
		`CHK("irq masked", 1'b0, irq_out)
		reg_wr(eth_tx_pkg::OFS_IRQ_MASK, 32'h1 << eth_tx_pkg::TX_DONE_BIT);
		`CHK("irq unmask", 1'b1, irq_out)
		reg_wr(eth_tx_pkg::OFS_STATUS, 32'h1 << eth_tx_pkg::TX_DONE_BIT);
		`CHK("irq w1c", 1'b0, irq_out)
		reg_wr(eth_tx_pkg::OFS_IRQ_MASK, 32'h1 << eth_tx_pkg::WB_DONE_BIT);
		`CHK("other irq", 1'b1, irq_out & ~partner.mem[0][31])
	endtask

	task automatic underflow_frame();
		reg_wr(eth_tx_pkg::OFS_IRQ_MASK, 32'h1 << eth_tx_pkg::UNDERFLOW_BIT);
		start_tx(32'd16, 4);
		starve();
		reg_rd(eth_tx_pkg::OFS_FIFO_STATE);
		`CHK("term", 1'b1, rd[eth_tx_pkg::FS_TERM_BIT])
		`CHK("rp max", 9'h1ff, rd[24:16])
		`CHK("irq uf", 1'b1, irq_out)
		reg_rd(eth_tx_pkg::OFS_STATUS);
		`CHK("uf bit", 1'b1, rd[eth_tx_pkg::UNDERFLOW_BIT])
		reg_rd(eth_tx_pkg::OFS_STATUS);
		`CHK("rd clear", 1'b0, rd[eth_tx_pkg::UNDERFLOW_BIT])
		poll(eth_tx_pkg::OFS_TX_REQUEST, 32'h1, 32'h0);
		`CHK("wb active", 1'b0, partner.mem[0][31])
		`CHK("wb err", 1'b1, partner.mem[0][8])
		`CHK("abort end", 1'b0, mac_abort_out)
	endtask

	task automatic stall_and_soft_reset();
		logic seen;
		seen = 1'b0;
		reg_wr(eth_tx_pkg::OFS_FIFO_DEPTH, 32'h4);
		reg_rd(eth_tx_pkg::OFS_FIFO_STATE);
		`CHK("risk", 1'b1, rd[eth_tx_pkg::FS_RISK_BIT])
		start_tx(32'd32, 8);
		starve();
		// Software timeout: check ownership once per period, give up after six
		for (int i = 0; i < 6 && partner.mem[0][31] === 1'b1; i++) begin
			repeat (10) @(posedge clk_in);
		end
		`CHK("timeout", 1'b1, partner.mem[0][31])
		reg_rd(eth_tx_pkg::OFS_FIFO_STATE);
		`CHK("stall", 1'b1, rd[eth_tx_pkg::FS_STALL_BIT])
		`CHK("full wp", 9'h0, rd[8:0])
		reg_rd(eth_tx_pkg::OFS_TX_REQUEST);
		`CHK("req held", 1'b1, rd[0])
		reg_wr(eth_tx_pkg::OFS_DMA_MODE, 32'h1);
		for (int i = 0; i < 4; i++) begin
			if (mac_reset_out === 1'b1 && rx_reset_out === 1'b1) seen = 1'b1;
			@(posedge clk_in);
			#1;
		end
		`CHK("mac rx reset", 1'b1, seen)
		reg_rd(eth_tx_pkg::OFS_FIFO_STATE);
		`CHK("stall gone", 1'b0, rd[eth_tx_pkg::FS_STALL_BIT])
		`CHK("wp min", 9'h0, rd[8:0])
		`CHK("rp max", 9'h1ff, rd[24:16])
		reg_rd(eth_tx_pkg::OFS_FIFO_DEPTH);
		`CHK("depth", 32'h200, rd)
	endtask

	initial begin
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		check_reset();
		normal_frame();
		underflow_frame();
		stall_and_soft_reset();
		complete_run();
	end
endmodule
